// File: hw/ext_edge_detect.sv
`timescale 1ns/1ps
module ext_edge_detect #(
    parameter int WIDTH = irq_arbiter_pkg::NUM_EXT
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [WIDTH-1:0] pinIn,
    input wire logic [WIDTH-1:0] risingSel,
    output logic [WIDTH-1:0] edgeSeen
);
    typedef struct packed {
        logic [WIDTH-1:0] sync1;
        logic [WIDTH-1:0] sync2;
        logic [WIDTH-1:0] prev;
    } edge_state_t;

    edge_state_t s;
    edge_state_t n;

    always_comb begin
        n = s;
        n.sync1 = pinIn;
        n.sync2 = s.sync1;
        n.prev = s.sync2;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // One pulse per qualifying edge, polarity chosen per input
    assign edgeSeen = (risingSel & s.sync2 & ~s.prev) | (~risingSel & ~s.sync2 & s.prev);

endmodule : ext_edge_detect

// File: hw/irq_arbiter_pkg.sv
package irq_arbiter_pkg;

    // Register map
    localparam logic [7:0] ADDR_CENTRAL_CTRL = 8'he6;
    localparam logic [7:0] ADDR_EDGE_SELECT = 8'hf2;
    localparam logic [7:0] ADDR_PENDING = 8'hf3;
    localparam logic [7:0] ADDR_MASK = 8'hf4;
    localparam logic [7:0] ADDR_PAIR_PRIORITY = 8'hf5;
    localparam logic [7:0] ADDR_NEST_STACK = 8'hf7;

    // Central control fields
    localparam int CTRL_LEVEL_LSB = 0;
    localparam int CTRL_MODE_BIT = 3;
    localparam int CTRL_ENABLE_BIT = 4;

    // Reset values
    localparam logic [2:0] RESET_LEVEL = 3'h7;
    localparam logic RESET_MODE = 1'b0;
    localparam logic RESET_ENABLE = 1'b0;
    localparam logic [7:0] RESET_EDGE_SELECT = 8'h00;
    localparam logic [7:0] RESET_PENDING = 8'h00;
    localparam logic [7:0] RESET_MASK = 8'h00;
    localparam logic [7:0] RESET_PAIR_PRIORITY = 8'h00;
    localparam logic [7:0] RESET_NEST_STACK = 8'h00;

    // Channel counts, chain order: ext 0..7, timer_zero_source, serial0, serial1, converter, timer_three_source, timer_one_source
    localparam int NUM_EXT = 8;
    localparam int NUM_PERIPH = 6;
    localparam int NUM_CHAN = NUM_EXT + NUM_PERIPH;
    localparam int CHAN_W = 4;

    // Timing counts in core clock cycles
    localparam logic [3:0] ARB_LEAD_CYCLES = 4'h6;
    localparam logic [2:0] WFI_SAMPLE_CYCLES = 3'h5;

    // Step codes shown to the sequencer
    localparam logic [2:0] STEP_PUSH_PC_LOW = 3'h0;
    localparam logic [2:0] STEP_PUSH_PC_HIGH = 3'h1;
    localparam logic [2:0] STEP_PUSH_FLAGS = 3'h2;
    localparam logic [2:0] STEP_LOAD_VECTOR = 3'h3;
    localparam logic [2:0] STEP_POP_FLAGS = 3'h4;
    localparam logic [2:0] STEP_POP_PC_HIGH = 3'h5;
    localparam logic [2:0] STEP_POP_PC_LOW = 3'h6;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_WAIT_END,
        ST_CLR_EN,
        ST_SAVE_LEVEL,
        ST_PUSH_PC_LOW,
        ST_PUSH_PC_HIGH,
        ST_PUSH_FLAGS,
        ST_LOAD_VECTOR,
        ST_POP_FLAGS,
        ST_POP_PC_HIGH,
        ST_POP_PC_LOW,
        ST_SET_EN,
        ST_RESTORE
    } seq_state_t;

endpackage : irq_arbiter_pkg

// File: hw/priority_irq_arbiter.sv
`timescale 1ns/1ps
module priority_irq_arbiter (
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic [irq_arbiter_pkg::NUM_EXT-1:0] extInput,
    input wire logic [irq_arbiter_pkg::NUM_PERIPH-1:0] periphReq,
    input wire logic [3*irq_arbiter_pkg::NUM_PERIPH-1:0] periphPriority,
    input wire logic topLevelReq,
    input wire logic [3:0] cyclesToEnd,
    input wire logic instrEnd,
    input wire logic waitIrq,
    input wire logic enableIrqInstr,
    input wire logic returnInstr,
    output logic ackValid,
    output logic [irq_arbiter_pkg::CHAN_W-1:0] ackChannel,
    output logic [irq_arbiter_pkg::NUM_PERIPH-1:0] periphAck,
    output logic topLevelAck,
    output logic stepValid,
    output logic [2:0] stepCode,
    output logic [2:0] currentLevel,
    output logic globalEnable
);
    import irq_arbiter_pkg::*;

    typedef struct packed {
        seq_state_t state;
        logic [2:0] level;
        logic enable;
        logic nestedMode;
        logic [7:0] edgeSel;
        logic [7:0] pend;
        logic [7:0] mask;
        logic [7:0] pairPrio;
        logic [7:0] nest;
        logic [7:0] rdData;
        logic wonTop;
        logic [CHAN_W-1:0] wonChan;
        logic [2:0] wonPrio;
        logic topActive;
        logic [2:0] wfiCnt;
        logic ackValid;
        logic [CHAN_W-1:0] ackChannel;
        logic [NUM_PERIPH-1:0] periphAck;
        logic topLevelAck;
        logic stepValid;
        logic [2:0] stepCode;
    } arb_state_t;

    localparam arb_state_t RESET_STATE = '{
        state: ST_IDLE,
        level: RESET_LEVEL,
        enable: RESET_ENABLE,
        nestedMode: RESET_MODE,
        edgeSel: RESET_EDGE_SELECT,
        pend: RESET_PENDING,
        mask: RESET_MASK,
        pairPrio: RESET_PAIR_PRIORITY,
        nest: RESET_NEST_STACK,
        rdData: 8'h00,
        wonTop: 1'b0,
        wonChan: 4'h0,
        wonPrio: 3'h7,
        topActive: 1'b0,
        wfiCnt: 3'h0,
        ackValid: 1'b0,
        ackChannel: 4'h0,
        periphAck: '0,
        topLevelAck: 1'b0,
        stepValid: 1'b0,
        stepCode: 3'h0
    };

    arb_state_t s;
    arb_state_t n;

    logic [NUM_EXT-1:0] edgeSeen;
    logic [NUM_CHAN-1:0] req;
    logic bestFound;
    logic [CHAN_W-1:0] bestIdx;
    logic [2:0] bestPrio;
    logic sampleNow;
    logic [NUM_EXT-1:0] pendClear;

    // Priority of a channel: external pairs from the pair field, others from the source
    function automatic logic [2:0] chanPrio(
        input int c,
        input logic [7:0] pairField,
        input logic [3*NUM_PERIPH-1:0] perPrio
    );
        logic [1:0] pairBits;
        pairBits = 2'h0;
        if (c < NUM_EXT) begin
            pairBits = pairField[(c / 2) * 2 +: 2];
            chanPrio = {pairBits, c[0]};
        end else begin
            chanPrio = perPrio[(c - NUM_EXT) * 3 +: 3];
        end
    endfunction : chanPrio

    function automatic logic [2:0] lowestSet(input logic [7:0] bits);
        lowestSet = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (bits[i]) begin
                lowestSet = 3'(i);
            end
        end
    endfunction : lowestSet

    ext_edge_detect #(
        .WIDTH(NUM_EXT)
    ) u_edges (
        .clock(clock),
        .srst(srst),
        .pinIn(extInput),
        .risingSel(s.edgeSel),
        .edgeSeen(edgeSeen)
    );

    always_comb begin
        n = s;
        n.ackValid = 1'b0;
        n.periphAck = '0;
        n.topLevelAck = 1'b0;
        n.stepValid = 1'b0;
        n.rdData = 8'h00;
        pendClear = '0;

        // Masked edges still land in pending; the mask only blocks the request
        for (int c = 0; c < NUM_EXT; c++) begin
            req[c] = s.pend[c] & s.mask[c] & s.enable;
        end
        for (int p = 0; p < NUM_PERIPH; p++) begin
            req[NUM_EXT + p] = periphReq[p] & s.enable;
        end

        // Strict less-than keeps earlier chain position on a tie
        bestFound = 1'b0;
        bestIdx = 4'h0;
        bestPrio = 3'h7;
        for (int c = 0; c < NUM_CHAN; c++) begin
            if (req[c] && (!bestFound || chanPrio(c, s.pairPrio, periphPriority) < bestPrio)) begin
                bestFound = 1'b1;
                bestIdx = 4'(c);
                bestPrio = chanPrio(c, s.pairPrio, periphPriority);
            end
        end

        // Sample point: fixed lead before end, or periodic while waiting
        if (waitIrq) begin
            n.wfiCnt = (s.wfiCnt == WFI_SAMPLE_CYCLES - 3'h1) ? 3'h0 : s.wfiCnt + 3'h1;
        end else begin
            n.wfiCnt = 3'h0;
        end
        sampleNow = waitIrq ? (s.wfiCnt == WFI_SAMPLE_CYCLES - 3'h1)
                            : (cyclesToEnd == ARB_LEAD_CYCLES);

        if (regRd) begin
            case (regAddr)
                ADDR_CENTRAL_CTRL: n.rdData = {3'h0, s.enable, s.nestedMode, s.level};
                ADDR_EDGE_SELECT: n.rdData = s.edgeSel;
                ADDR_PENDING: n.rdData = s.pend;
                ADDR_MASK: n.rdData = s.mask;
                ADDR_PAIR_PRIORITY: n.rdData = s.pairPrio;
                ADDR_NEST_STACK: n.rdData = s.nest;
                default: n.rdData = 8'h00;
            endcase
        end

        if (regWr) begin
            case (regAddr)
                ADDR_CENTRAL_CTRL: begin
                    n.level = regWrData[CTRL_LEVEL_LSB +: 3];
                    n.nestedMode = regWrData[CTRL_MODE_BIT];
                    n.enable = regWrData[CTRL_ENABLE_BIT];
                end
                ADDR_EDGE_SELECT: n.edgeSel = regWrData;
                ADDR_PENDING: n.pend = regWrData;
                ADDR_MASK: n.mask = regWrData;
                ADDR_PAIR_PRIORITY: n.pairPrio = regWrData;
                ADDR_NEST_STACK: n.nest = regWrData;
                default: begin
                end
            endcase
        end

        if (enableIrqInstr) begin
            n.enable = 1'b1;
        end

        // Sequencer acts after software so its own updates win a same-cycle clash
        case (s.state)
            ST_IDLE: begin
                if (returnInstr) begin
                    n.state = ST_POP_FLAGS;
                end else if (sampleNow && !s.topActive) begin
                    if (topLevelReq) begin
                        n.wonTop = 1'b1;
                        n.state = ST_WAIT_END;
                    end else if (bestFound && bestPrio < s.level) begin
                        n.wonTop = 1'b0;
                        n.wonChan = bestIdx;
                        n.wonPrio = bestPrio;
                        n.state = ST_WAIT_END;
                    end
                end
            end
            ST_WAIT_END: begin
                // In the wait state there is no instruction to finish
                if (instrEnd || waitIrq) begin
                    n.state = ST_CLR_EN;
                    if (s.wonTop) begin
                        n.topLevelAck = 1'b1;
                        n.topActive = 1'b1;
                    end else begin
                        n.ackValid = 1'b1;
                        n.ackChannel = s.wonChan;
                        if (s.wonChan < 4'(NUM_EXT)) begin
                            pendClear[s.wonChan[2:0]] = 1'b1;
                        end else begin
                            n.periphAck[3'(s.wonChan - 4'(NUM_EXT))] = 1'b1;
                        end
                    end
                end
            end
            ST_CLR_EN: begin
                if (!s.wonTop) begin
                    n.enable = 1'b0;
                end
                // Concurrent mode keeps no trace of the source level
                n.state = (s.nestedMode && !s.wonTop) ? ST_SAVE_LEVEL : ST_PUSH_PC_LOW;
            end
            ST_SAVE_LEVEL: begin
                // Both read the old level, so save precedes load
                n.nest[s.level] = 1'b1;
                n.level = s.wonPrio;
                n.state = ST_PUSH_PC_LOW;
            end
            ST_PUSH_PC_LOW: begin
                n.stepValid = 1'b1;
                n.stepCode = STEP_PUSH_PC_LOW;
                n.state = ST_PUSH_PC_HIGH;
            end
            ST_PUSH_PC_HIGH: begin
                n.stepValid = 1'b1;
                n.stepCode = STEP_PUSH_PC_HIGH;
                n.state = ST_PUSH_FLAGS;
            end
            ST_PUSH_FLAGS: begin
                n.stepValid = 1'b1;
                n.stepCode = STEP_PUSH_FLAGS;
                n.state = ST_LOAD_VECTOR;
            end
            ST_LOAD_VECTOR: begin
                n.stepValid = 1'b1;
                n.stepCode = STEP_LOAD_VECTOR;
                n.state = ST_IDLE;
            end
            ST_POP_FLAGS: begin
                n.stepValid = 1'b1;
                n.stepCode = STEP_POP_FLAGS;
                n.state = ST_POP_PC_HIGH;
            end
            ST_POP_PC_HIGH: begin
                n.stepValid = 1'b1;
                n.stepCode = STEP_POP_PC_HIGH;
                n.state = ST_POP_PC_LOW;
            end
            ST_POP_PC_LOW: begin
                n.stepValid = 1'b1;
                n.stepCode = STEP_POP_PC_LOW;
                n.state = ST_SET_EN;
            end
            ST_SET_EN: begin
                if (s.topActive) begin
                    n.topActive = 1'b0;
                    n.state = ST_IDLE;
                end else begin
                    n.enable = 1'b1;
                    n.state = s.nestedMode ? ST_RESTORE : ST_IDLE;
                end
            end
            ST_RESTORE: begin
                // An empty stack leaves the level as software left it
                if (|s.nest) begin
                    n.level = lowestSet(s.nest);
                    n.nest[lowestSet(s.nest)] = 1'b0;
                end
                n.state = ST_IDLE;
            end
            default: n.state = ST_IDLE;
        endcase

        // New edge beats a same-cycle clear from software or acknowledge
        n.pend = (n.pend & ~pendClear) | edgeSeen;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s <= RESET_STATE;
        end else begin
            s <= n;
        end
    end

    assign regRdData = s.rdData;
    assign ackValid = s.ackValid;
    assign ackChannel = s.ackChannel;
    assign periphAck = s.periphAck;
    assign topLevelAck = s.topLevelAck;
    assign stepValid = s.stepValid;
    assign stepCode = s.stepCode;
    assign currentLevel = s.level;
    assign globalEnable = s.enable;

endmodule : priority_irq_arbiter

// File: tb/core_seq_model.sv
`timescale 1ns/1ps
module core_seq_model (
    input wire logic clock,
    input wire logic srst,
    input wire logic waitIrq,
    input wire logic [5:0] periphSet,
    input wire logic periphClr,
    input wire logic [5:0] periphAck,
    output logic [5:0] periphReq,
    output logic [3:0] cyclesToEnd,
    output logic instrEnd
);
    logic [3:0] count_reg;
    logic [5:0] pend_reg;
    logic slow_reg;
    always_ff @(posedge clock) begin
        if (srst) begin
            count_reg <= 4'h9;
            pend_reg <= 6'h00;
            slow_reg <= 1'b0;
        end else begin
            // Core clock halted in wait state, so the count freezes
            if (!waitIrq) begin
                count_reg <= (count_reg == 4'h0) ? (slow_reg ? 4'hb : 4'h8) : count_reg - 4'h1;
            end
            // Alternate short and long instructions
            if (!waitIrq && count_reg == 4'h0) begin
                slow_reg <= ~slow_reg;
            end
            pend_reg <= periphClr ? 6'h00 : (pend_reg | periphSet) & ~periphAck;
        end
    end
    assign periphReq = pend_reg;
    assign cyclesToEnd = count_reg;
    assign instrEnd = count_reg == 4'h0 && !waitIrq;
endmodule : core_seq_model

// File: tb/irq_arbiter_checker.sv
`timescale 1ns/1ps
module irq_arbiter_checker
    import irq_arbiter_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic [3*NUM_PERIPH-1:0] periphPriority,
    input wire logic [3:0] cyclesToEnd,
    input wire logic instrEnd,
    input wire logic waitIrq,
    input wire logic ackValid,
    input wire logic [CHAN_W-1:0] ackChannel,
    input wire logic [NUM_PERIPH-1:0] periphAck,
    input wire logic topLevelAck,
    input wire logic stepValid,
    input wire logic [2:0] stepCode,
    input wire logic [2:0] currentLevel,
    input wire logic globalEnable
);
    function automatic logic [2:0] prio(input logic [3:0] ch, input logic [17:0] p);
        int i;
        i = 3 * (int'(ch) - 8);
        return p[i +: 3];
    endfunction : prio
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    reset_level_a: assert property (disable iff (1'b0) srst |=> currentLevel == 3'h7 && !globalEnable)
        else $error("bad state after reset");
    ack_end_a: assert property (ackValid && !$past(waitIrq) |-> $past(instrEnd))
        else $error("ack not after instruction end");
    // Winner is latched at the lead point and acknowledged the cycle after the end
    sample_lead_a: assert property ((ackValid || topLevelAck) && !$past(waitIrq) |-> $past(cyclesToEnd, 7) == ARB_LEAD_CYCLES)
        else $error("arbitration not at lead point");
    clear_enable_a: assert property (ackValid |=> !globalEnable)
        else $error("enable not cleared on entry");
    entry_start_a: assert property ((ackValid || topLevelAck) |-> ##[2:3] stepValid && stepCode == STEP_PUSH_PC_LOW)
        else $error("entry pushes missing");
    entry_order_a: assert property (stepValid && stepCode == STEP_PUSH_PC_LOW |=> stepValid && stepCode == STEP_PUSH_PC_HIGH ##1 stepValid && stepCode == STEP_PUSH_FLAGS ##1 stepValid && stepCode == STEP_LOAD_VECTOR)
        else $error("entry step order wrong");
    return_order_a: assert property (stepValid && stepCode == STEP_POP_FLAGS |=> stepValid && stepCode == STEP_POP_PC_HIGH ##1 stepValid && stepCode == STEP_POP_PC_LOW)
        else $error("return step order wrong");
    top_enable_a: assert property (topLevelAck |=> $stable(globalEnable) [*5])
        else $error("top entry changed enable");
    periph_ack_a: assert property (ackValid && ackChannel >= 4'h8 |-> periphAck == 6'h01 << (ackChannel - 4'h8))
        else $error("peripheral ack bit wrong");
    win_level_a: assert property (ackValid && ackChannel >= 4'h8 |-> prio(ackChannel, periphPriority) < currentLevel)
        else $error("ack level not above current");
    read_idle_a: assert property (regRdData != 8'h00 |-> $past(regRd))
        else $error("read data outside read cycle");
endmodule : irq_arbiter_checker

// File: tb/tb_priority_irq_arbiter.sv
`timescale 1ns/1ps
module tb_priority_irq_arbiter;
    import irq_arbiter_pkg::*;
    typedef struct {logic [5:0] req; logic [17:0] pri; logic [3:0] ch;} row_t;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdData;
    logic [7:0] extInput = 8'h00;
    logic [17:0] periphPriority = 18'h0;
    logic topLevelReq = 1'b0;
    logic waitIrq = 1'b0;
    logic enableIrqInstr = 1'b0;
    logic returnInstr = 1'b0;
    logic [5:0] periphSet = 6'h00;
    logic periphClr = 1'b0;
    logic [5:0] periphReq, periphAck;
    logic [3:0] cyclesToEnd, ackChannel;
    logic [2:0] stepCode, currentLevel;
    logic instrEnd, ackValid, topLevelAck, stepValid, globalEnable, got;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] regList [6] = '{ADDR_CENTRAL_CTRL, ADDR_EDGE_SELECT, ADDR_PENDING,
        ADDR_MASK, ADDR_PAIR_PRIORITY, ADDR_NEST_STACK};
    row_t rows [6] = '{
        '{6'h01, 18'h00003, 4'h8}, '{6'h3f, 18'h12492, 4'h8}, '{6'h05, 18'h00044, 4'ha},
        '{6'h28, 18'h00000, 4'hb}, '{6'h20, 18'h38000, 4'hf}, '{6'h10, 18'h06000, 4'hc}};

    always #12.5 clock = ~clock;

    core_seq_model partner (.clock(clock), .srst(srst), .waitIrq(waitIrq),
        .periphSet(periphSet), .periphClr(periphClr), .periphAck(periphAck),
        .periphReq(periphReq), .cyclesToEnd(cyclesToEnd), .instrEnd(instrEnd));

    priority_irq_arbiter DUT (.clock(clock), .srst(srst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .extInput(extInput), .periphReq(periphReq), .periphPriority(periphPriority),
        .topLevelReq(topLevelReq), .cyclesToEnd(cyclesToEnd), .instrEnd(instrEnd),
        .waitIrq(waitIrq), .enableIrqInstr(enableIrqInstr), .returnInstr(returnInstr),
        .ackValid(ackValid), .ackChannel(ackChannel), .periphAck(periphAck),
        .topLevelAck(topLevelAck), .stepValid(stepValid), .stepCode(stepCode),
        .currentLevel(currentLevel), .globalEnable(globalEnable));

    task automatic summarize();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    always @(posedge clock) begin
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            summarize();
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        chk(regRdData, e);
    endtask : rd

    // 0 enable instruction, 1 return, 2 drop all peripheral pendings
    task automatic strobe(input int which, input logic [5:0] req);
        @(posedge clock);
        enableIrqInstr <= which == 0;
        returnInstr <= which == 1;
        periphClr <= which == 2;
        periphSet <= req;
        @(posedge clock);
        {enableIrqInstr, returnInstr, periphClr, periphSet} <= 9'h000;
    endtask : strobe

    task automatic waitAck(input int n);
        got = 1'b0;
        repeat (n) begin
            @(posedge clock);
            #1;
            if (ackValid === 1'b1 || topLevelAck === 1'b1) begin
                got = 1'b1;
                break;
            end
        end
    endtask : waitAck

    initial begin
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        foreach (rows[i]) begin
            strobe(2, 6'h00);
            periphPriority <= rows[i].pri;
            strobe(0, rows[i].req); // Enable only outside a routine
            waitAck(40);
            chk({7'h0, got}, {7'h0, rows[i].ch != 4'hf});
            if (got) begin
                chk({4'h0, ackChannel}, {4'h0, rows[i].ch});
                repeat (8) @(posedge clock);
                chk({5'h0, currentLevel}, 8'h07);
                strobe(2, 6'h00);
                strobe(1, 6'h00);
                repeat (8) @(posedge clock);
                chk({7'h0, globalEnable}, 8'h01);
            end
        end
        srst <= 1'b1;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        foreach (regList[i]) rd(regList[i], i == 0 ? 8'h07 : 8'h00);
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00);
        wr(ADDR_EDGE_SELECT, 8'h01);
        wr(ADDR_MASK, 8'h01);
        wr(ADDR_PAIR_PRIORITY, 8'h01);
        extInput <= 8'h03;
        repeat (5) @(posedge clock);
        extInput <= 8'h01;
        repeat (5) @(posedge clock);
        rd(ADDR_PENDING, 8'h03);
        strobe(0, 6'h00);
        waitAck(40);
        chk({3'h0, got, ackChannel}, 8'h10);
        repeat (8) @(posedge clock);
        rd(ADDR_PENDING, 8'h02);
        strobe(1, 6'h00);
        repeat (8) @(posedge clock);
        wr(ADDR_CENTRAL_CTRL, 8'h0d);
        rd(ADDR_CENTRAL_CTRL, 8'h0d);
        @(posedge clock) periphPriority <= 18'h0001b;
        strobe(0, 6'h01);
        waitAck(40);
        repeat (8) @(posedge clock);
        chk({5'h0, currentLevel}, 8'h03);
        rd(ADDR_NEST_STACK, 8'h20);
        strobe(0, 6'h02);
        waitAck(30);
        chk({7'h0, got}, 8'h00);
        strobe(2, 6'h00);
        strobe(1, 6'h00);
        repeat (8) @(posedge clock);
        chk({5'h0, currentLevel}, 8'h05);
        rd(ADDR_NEST_STACK, 8'h00);
        @(posedge clock);
        periphPriority <= 18'h0;
        topLevelReq <= 1'b1;
        strobe(0, 6'h01);
        waitAck(40);
        chk({6'h0, got, topLevelAck}, 8'h03);
        @(posedge clock) topLevelReq <= 1'b0;
        waitAck(30);
        chk({6'h0, got, globalEnable}, 8'h01);
        strobe(2, 6'h00);
        strobe(1, 6'h00);
        repeat (8) @(posedge clock);
        waitIrq <= 1'b1;
        periphPriority <= 18'h00003;
        strobe(0, 6'h01);
        // Fifth cycle of waiting samples, so the ack lands exactly two cycles later
        waitAck(3);
        chk({7'h0, got}, 8'h00);
        waitAck(1);
        chk({7'h0, got}, 8'h01);
        @(posedge clock) waitIrq <= 1'b0;
        repeat (8) @(posedge clock);
        summarize();
    end
endmodule : tb_priority_irq_arbiter

bind priority_irq_arbiter irq_arbiter_checker chk_i (.*);
